// ---- dv/eqco_host_model.sv ----
// Host model: Avalon-MM master that runs one register transfer per call.
// Assumes the slave answers through waitrequest; the bench owns the timeout.
`timescale 1ns/1ps
`default_nettype none
module eqco_host_model (
  // Clock
  input  wire logic        clk_in,
  // Register bus
  output var  logic [4:0]  avs_address_out,
  output var  logic        avs_read_out,
  output var  logic        avs_write_out,
  output var  logic [31:0] avs_writedata_out,
  output var  logic [3:0]  avs_byteenable_out,
  input  wire logic [31:0] avs_readdata_in,
  input  wire logic        avs_waitrequest_in,
  // Read results
  output var  logic        rd_stb_out,
  output var  logic [7:0]  rd_data_out
);
  initial begin
    avs_address_out    = 5'h00;
    avs_read_out       = 1'b0;
    avs_write_out      = 1'b0;
    avs_writedata_out  = 32'h00000000;
    avs_byteenable_out = 4'hF;
    rd_stb_out         = 1'b0;
    rd_data_out        = 8'h00;
  end

  // Request held until waitrequest is sampled low; stale data inverted after
  task automatic xfer(input logic wr, input logic [4:0] adr, input logic [7:0] dat);
    @(posedge clk_in);
    avs_address_out   <= adr;
    avs_writedata_out <= {24'h000000, dat};
    avs_read_out      <= !wr;
    avs_write_out     <= wr;
    do @(posedge clk_in); while (avs_waitrequest_in !== 1'b0);
    avs_read_out      <= 1'b0;
    avs_write_out     <= 1'b0;
    avs_writedata_out <= ~avs_writedata_out;
    rd_stb_out        <= !wr;
    rd_data_out       <= avs_readdata_in[7:0];
    @(posedge clk_in);
    rd_stb_out <= 1'b0;
  endtask : xfer
endmodule : eqco_host_model
`default_nettype wire

// ---- dv/tb_equalizer_config_observe.sv ----
// Self-checking bench for the equalizer configuration block.
// Assumes eqco_host_model drives the register bus.
`timescale 1ns/1ps
`default_nettype none
module tb_equalizer_config_observe
  import eqco_pkg::*;
;
  logic                    clk_in = 1'b0;
  logic                    rstn_in = 1'b0;
  logic [4:0]              adr;
  logic                    rd, wr, wq, rstb, sstb = 1'b0;
  logic [31:0]             wd, rdat;
  logic [3:0]              be;
  logic [7:0]              rval, sval, freq = 8'h80, eye_code, pin_a, pin_b;
  eqco_chan_t [NUM_CH-1:0] chans = '0;
  logic                    env = 1'b0, tk = 1'b0, in_norm = 1'b1;
  logic                    eye_en, main, aux, envp, sleep, syncr, leak, ext;
  logic [1:0]              span;
  logic [2:0]              gain;
  logic [7:0]              exp_q[$];
  logic [7:0]              mode_exp[4] = '{8'h18, 8'h0C, 8'h03, 8'h03};
  int                      n_checks = 0, n_mismatch = 0, cyc = 0, seed = 94;

  always #5 clk_in = ~clk_in;

  eqco_host_model i_host (.clk_in(clk_in), .avs_address_out(adr), .avs_read_out(rd),
    .avs_write_out(wr), .avs_writedata_out(wd), .avs_byteenable_out(be),
    .avs_readdata_in(rdat), .avs_waitrequest_in(wq), .rd_stb_out(rstb), .rd_data_out(rval));

  eqco_top i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .chan_in(chans), .clk_freq_in(freq),
    .aux_envelope_bit_in(env), .sync_lock_in(1'b0), .bit_period_tick_in(tk),
    .freq_in_normal_in(in_norm), .eye_dac_enable_out(eye_en), .eye_dac_code_out(eye_code),
    .test_out_pin_a_out(pin_a), .test_out_pin_b_out(pin_b), .main_eq_enable_out(main),
    .aux_eq_enable_out(aux), .envelope_proc_enable_out(envp), .eq_sleep_out(sleep),
    .sync_ready_flag_out(syncr), .loop_leak_enable_out(leak), .pll_span_select_out(span),
    .extended_range_out(ext), .loop_gain_out(gain));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Expected results come off the queue in order as reads or samples appear
  always @(posedge clk_in) begin
    if (rstb === 1'b1) check(rval, exp_q.pop_front());
    if (sstb === 1'b1) check(sval, exp_q.pop_front());
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, d);
    // Registered outputs need one more edge before a probe samples them
    @(posedge clk_in);
  endtask : wr_reg

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.xfer(1'b0, a, 8'h00);
  endtask : rd_chk

  task automatic probe(input logic [7:0] v, input logic [7:0] e);
    @(posedge clk_in);
    exp_q.push_back(e);
    sval <= v;
    sstb <= 1'b1;
    @(posedge clk_in);
    sstb <= 1'b0;
  endtask : probe

  task automatic shuffle;
    chans <= 90'({$random(seed), $random(seed), $random(seed)});
    freq  <= 8'($random(seed));
  endtask : shuffle

  task automatic rise;
    env <= 1'b1;
    repeat (2) @(posedge clk_in);
    env <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : rise

  task automatic tick(input logic norm);
    in_norm <= norm;
    tk      <= 1'b1;
    @(posedge clk_in);
    tk <= 1'b0;
    @(posedge clk_in);
  endtask : tick

  function automatic logic [7:0] sel(input logic [2:0] f, input logic [3:0] c);
    if (f == FN_FREQ) return freq;
    if (c > 4'h8 || f == FN_OFF || f > FN_FREQ) return 8'h00;
    if (f == FN_EYE) return chans[c].eye;
    return {7'h00, (f == FN_SLICE) ? chans[c].sliced : chans[c].bit_clk};
  endfunction : sel

  initial begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd_chk(OFS_EYE, RST_EYE);
    rd_chk(OFS_PIN_A, RST_PIN);
    rd_chk(OFS_PIN_A + PIN_STRIDE, RST_PIN);
    rd_chk(OFS_EQ, RST_EQ);
    rd_chk(OFS_CLK, RST_CLK);
    rd_chk(5'h02, 8'h00);
    probe({leak, span, ext, 1'b0, gain}, 8'h81);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      shuffle();
      wr_reg(OFS_EYE, 8'h10 | 8'(i));
      probe(eye_code, (i < 9) ? chans[i].eye : 8'h00);
    end
    wr_reg(OFS_EYE, 8'h08);
    probe(eye_code, EYE_IDLE);
    probe({7'h00, eye_en}, 8'h00);
    wr_reg(OFS_EYE, 8'hFF);
    rd_chk(OFS_EYE, 8'h1F);
    for (int i = 0; i < 16; i++) begin
      shuffle();
      wr_reg(OFS_PIN_A, 8'h10 | 8'(i));
      probe(pin_a, sel(FN_EYE, 4'(i)));
    end
    for (int f = 0; f < 8; f++) begin
      shuffle();
      wr_reg(OFS_PIN_A + PIN_STRIDE, {1'b0, 3'(f), 4'(f + 1)});
      probe(pin_b, sel(3'(f), 4'(f + 1)));
    end
    $display("routing test done");
    for (int m = 0; m < 4; m++) begin
      wr_reg(OFS_EQ, 8'(m));
      probe({3'h0, main, aux, envp, sleep, syncr}, mode_exp[m]);
    end
    wr_reg(OFS_PIN_A, 8'h33);
    rd_chk(OFS_PIN_A, 8'h00);
    wr_reg(OFS_EQ, 8'h05);
    rd_chk(OFS_PIN_A, 8'h1F);
    wr_reg(OFS_CNT_LO, 8'hFF);
    wr_reg(OFS_CNT_HI, 8'h00);
    rise();
    rise();
    rd_chk(OFS_CNT_LO, 8'h01);
    rd_chk(OFS_CNT_HI, 8'h01);
    wr_reg(OFS_EQ, 8'h01);
    rise();
    wr_reg(OFS_EQ, 8'h00);
    rise();
    rd_chk(OFS_CNT_LO, 8'h00);
    rd_chk(OFS_CNT_HI, 8'h01);
    $display("mode test done");
    wr_reg(OFS_CLK, 8'hA4); // extended gain code below 11
    probe({leak, span, ext, 1'b0, gain}, 8'hA2);
    tick(1'b0);
    probe({leak, span, ext, 1'b0, gain}, 8'hB3);
    repeat (30) tick(1'b1);
    tick(1'b0);
    repeat (63) tick(1'b1);
    probe({leak, span, ext, 1'b0, gain}, 8'hB3);
    tick(1'b1);
    probe({leak, span, ext, 1'b0, gain}, 8'hA2);
    wr_reg(OFS_CLK, 8'h84);
    tick(1'b0);
    probe({leak, span, ext, 1'b0, gain}, 8'h82);
    wr_reg(OFS_CLK, 8'h38);
    probe({leak, span, ext, 1'b0, gain}, 8'h21);
    $display("clock recovery test done");
    tally_and_finish();
  end
endmodule : tb_equalizer_config_observe
`default_nettype wire

// ---- src/eqco_pkg.sv ----
// Constants and types for the equalizer configuration and observation block.
// Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM register bus.
package eqco_pkg;

  // ----------------------------------------------------------------------
  // Channels and codes
  // ----------------------------------------------------------------------
  localparam int       NUM_CH    = 9;
  localparam logic [3:0] CHAN_AUX = 4'h8;
  localparam logic [2:0] FN_OFF   = 3'h0;
  localparam logic [2:0] FN_EYE   = 3'h1;
  localparam logic [2:0] FN_SLICE = 3'h2;
  localparam logic [2:0] FN_BCLK  = 3'h3;
  localparam logic [2:0] FN_FREQ  = 3'h4;
  localparam logic [7:0] EYE_IDLE = 8'hFF;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFS_EYE    = 5'h00;
  localparam logic [4:0] OFS_PIN_A  = 5'h04;
  localparam logic [4:0] PIN_STRIDE = 5'h04;
  localparam logic [4:0] OFS_EQ     = 5'h0C;
  localparam logic [4:0] OFS_CLK    = 5'h10;
  localparam logic [4:0] OFS_CNT_LO = 5'h14;
  localparam logic [4:0] OFS_CNT_HI = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;
  localparam logic [7:0] RST_EYE    = 8'h00;
  localparam logic [7:0] RST_PIN    = 8'h00;
  localparam logic [7:0] RST_EQ     = 8'h00;
  localparam logic [7:0] RST_CLK    = 8'h9A;

  // ----------------------------------------------------------------------
  // Clock recovery timing
  // ----------------------------------------------------------------------
  localparam logic [9:0] RET_BASE   = 10'h040;
  localparam logic [2:0] GAIN_ONE   = 3'h1;
  localparam logic [2:0] GAIN_TWO   = 3'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SEARCH = 2'b01,
    MODE_OFF    = 2'b10,
    MODE_OFF_B  = 2'b11
  } eqco_mode_t;

  typedef enum logic {
    PLL_NORMAL   = 1'b0,
    PLL_EXTENDED = 1'b1
  } eqco_pll_t;

  typedef struct packed {
    logic [7:0] eye;
    logic       sliced;
    logic       bit_clk;
  } eqco_chan_t;

  typedef struct packed {
    logic [2:0] unused;
    logic       eye_dac_enable;
    logic [3:0] eye_channel_field;
  } eqco_eye_sel_t;

  typedef struct packed {
    logic       unused;
    logic [2:0] function_field;
    logic [3:0] channel_field;
  } eqco_pin_sel_t;

  typedef struct packed {
    logic [4:0] unused;
    logic       count_up_select;
    eqco_mode_t equalizer_mode_field;
  } eqco_eq_setup_t;

  typedef struct packed {
    logic       loop_leak_enable;
    logic [1:0] pll_span_select;
    logic       normal_gain_select;
    logic [1:0] extended_gain_field;
    logic [1:0] lock_return_delay;
  } eqco_clk_setup_t;

endpackage : eqco_pkg

// ---- src/eqco_top.sv ----
// Equalizer configuration registers, eye and test pin routing, envelope counter
// and clock recovery range control.
// Assumes channel data, envelope and PLL status come from logic on clk_in.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Eye enable low: DAC off, output high
// - Eye channel code routes main or aux
// - Pin A function code selects output source
// - Pin A channel code routes main or aux
// - Pin B function code selects output source
// - Pin B channel code routes main or aux
// - Eye two's complement, slice and clock binary
// - Clock frequency output as offset binary
// - Envelope counter steps by one on rise
// - Mode field: normal, search, off
// - Normal: all channels, no envelope processing
// - Search: only aux channel equalized
// - Off: sleep, sync ready output high
// - Off: other registers not addressable
// - Leak bit enables loop filter leakage
// - Span field sets frequency range
// - Span zero never enters extended range
// - Normal gain bit: two or one
// - Extended gain field: two to five
// - Return after consecutive in-range bit periods
// - Envelope is a one-bit indication
// - Counter sixteen bits, two bytes, low first
module eqco_top
  import eqco_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  // Avalon-MM slave
  input  wire logic [4:0]              avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output var  logic [31:0]             avs_readdata_out,
  output var  logic                    avs_waitrequest_out,
  // Equalizer observation inputs
  input  wire eqco_chan_t [NUM_CH-1:0] chan_in,
  input  wire logic [7:0]              clk_freq_in,
  input  wire logic                    aux_envelope_bit_in,
  input  wire logic                    sync_lock_in,
  // Clock recovery status inputs
  input  wire logic                    bit_period_tick_in,
  input  wire logic                    freq_in_normal_in,
  // Eye and test pins
  output var  logic                    eye_dac_enable_out,
  output var  logic [7:0]              eye_dac_code_out,
  output var  logic [7:0]              test_out_pin_a_out,
  output var  logic [7:0]              test_out_pin_b_out,
  // Equalizer control
  output var  logic                    main_eq_enable_out,
  output var  logic                    aux_eq_enable_out,
  output var  logic                    envelope_proc_enable_out,
  output var  logic                    eq_sleep_out,
  output var  logic                    sync_ready_flag_out,
  // Clock recovery control
  output var  logic                    loop_leak_enable_out,
  output var  logic [1:0]              pll_span_select_out,
  output var  logic                    extended_range_out,
  output var  logic [2:0]              loop_gain_out
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  eqco_eye_sel_t   eye_sel_ff;
  eqco_pin_sel_t   pin_sel_ff [2];
  eqco_eq_setup_t  eq_setup_ff;
  eqco_clk_setup_t clk_setup_ff;
  logic [15:0]     envelope_counter_ff;
  logic [7:0]      cnt_lo_hold_ff;
  logic [7:0]      cnt_hi_snap_ff;
  logic            ack_ff;
  logic [31:0]     readdata_ff;
  logic            req;
  logic            wr_take;
  logic            rd_take;
  logic            sleeping;
  logic            reachable;
  logic [7:0]      nxt_rdata;
  logic [7:0]      wbyte;

  assign req       = avs_read_in | avs_write_in;
  assign wr_take   = avs_write_in & ack_ff;
  assign rd_take   = avs_read_in & ack_ff;
  assign wbyte     = avs_writedata_in[7:0];
  assign sleeping  = eq_setup_ff.equalizer_mode_field[1];
  // In sleep only the mode register stays reachable
  assign reachable = (avs_address_in == OFS_EQ) | ~sleeping;

  assign avs_waitrequest_out = req & ~ack_ff;
  assign avs_readdata_out    = readdata_ff;

  // One wait cycle, then the answer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (reachable) begin
      case (avs_address_in)
        OFS_EYE:    nxt_rdata = eye_sel_ff;
        OFS_PIN_A:  nxt_rdata = pin_sel_ff[0];
        OFS_PIN_A + PIN_STRIDE: nxt_rdata = pin_sel_ff[1];
        OFS_EQ:     nxt_rdata = eq_setup_ff;
        OFS_CLK:    nxt_rdata = clk_setup_ff;
        OFS_CNT_LO: nxt_rdata = envelope_counter_ff[7:0];
        OFS_CNT_HI: nxt_rdata = cnt_hi_snap_ff;
        OFS_STATUS: nxt_rdata = {5'h00, sleeping, sync_ready_flag_out, extended_range_out};
        default:    nxt_rdata = 8'h00;
      endcase
    end
  end

  // Unused bits and blocked or unmapped reads give zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      readdata_ff <= 32'h0000_0000;
    end else if (avs_read_in & ~ack_ff) begin
      readdata_ff <= {24'h00_0000, nxt_rdata};
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic cfg_wr;
  assign cfg_wr = wr_take & avs_byteenable_in[0] & reachable;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eye_sel_ff <= RST_EYE;
    end else if (cfg_wr && avs_address_in == OFS_EYE) begin
      eye_sel_ff <= {3'h0, wbyte[4:0]};
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eq_setup_ff <= RST_EQ;
    end else if (cfg_wr && avs_address_in == OFS_EQ) begin
      eq_setup_ff <= {5'h00, wbyte[2:0]};
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_setup_ff <= RST_CLK;
    end else if (cfg_wr && avs_address_in == OFS_CLK) begin
      clk_setup_ff <= wbyte;
    end
  end

  // ----------------------------------------------------------------------
  // Channel routing
  // ----------------------------------------------------------------------
  function automatic eqco_chan_t pick_chan(input logic [3:0] code,
                                           input eqco_chan_t [NUM_CH-1:0] chans);
    eqco_chan_t res;
    res = '0;
    if (code <= CHAN_AUX) begin
      res = chans[code];
    end
    return res;
  endfunction : pick_chan

  function automatic logic [7:0] pin_value(input eqco_pin_sel_t sel,
                                           input eqco_chan_t [NUM_CH-1:0] chans,
                                           input logic [7:0] freq);
    eqco_chan_t ch;
    logic [7:0] res;
    ch  = pick_chan(sel.channel_field, chans);
    res = 8'h00;
    case (sel.function_field)
      FN_OFF:   res = 8'h00;
      FN_EYE:   res = ch.eye;
      FN_SLICE: res = {7'h00, ch.sliced};
      FN_BCLK:  res = {7'h00, ch.bit_clk};
      FN_FREQ:  res = freq;
      default:  res = 8'h00;
    endcase
    return res;
  endfunction : pin_value

  logic [7:0] eye_code_ff;
  eqco_chan_t eye_pick;
  assign eye_pick           = pick_chan(eye_sel_ff.eye_channel_field, chan_in);
  assign eye_dac_enable_out = eye_sel_ff.eye_dac_enable;
  assign eye_dac_code_out   = eye_code_ff;

  // Disabled DAC parks the output high
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eye_code_ff <= EYE_IDLE;
    end else if (!eye_sel_ff.eye_dac_enable) begin
      eye_code_ff <= EYE_IDLE;
    end else begin
      eye_code_ff <= eye_pick.eye;
    end
  end

  logic [7:0] pin_out_ff [2];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_pin
      localparam logic [4:0] PIN_OFS = OFS_PIN_A + 5'(g) * PIN_STRIDE;

      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          pin_sel_ff[g] <= RST_PIN;
        end else if (cfg_wr && avs_address_in == PIN_OFS) begin
          pin_sel_ff[g] <= {1'b0, wbyte[6:0]};
        end
      end

      // Function and channel mux, reserved codes give zero
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          pin_out_ff[g] <= 8'h00;
        end else begin
          pin_out_ff[g] <= pin_value(pin_sel_ff[g], chan_in, clk_freq_in);
        end
      end
    end
  endgenerate

  assign test_out_pin_a_out = pin_out_ff[0];
  assign test_out_pin_b_out = pin_out_ff[1];

  // ----------------------------------------------------------------------
  // Equalizer mode
  // ----------------------------------------------------------------------
  always_comb begin
    main_eq_enable_out       = 1'b0;
    aux_eq_enable_out        = 1'b0;
    envelope_proc_enable_out = 1'b0;
    eq_sleep_out             = 1'b0;
    case (eq_setup_ff.equalizer_mode_field)
      MODE_NORMAL: begin
        main_eq_enable_out = 1'b1;
        aux_eq_enable_out  = 1'b1;
      end
      MODE_SEARCH: begin
        aux_eq_enable_out        = 1'b1;
        envelope_proc_enable_out = 1'b1;
      end
      default: begin
        eq_sleep_out = 1'b1;
      end
    endcase
  end

  assign sync_ready_flag_out = sleeping | sync_lock_in;

  // ----------------------------------------------------------------------
  // Envelope counter
  // ----------------------------------------------------------------------
  logic env_prev_ff;
  logic env_rise;
  logic cnt_load;
  assign env_rise = aux_envelope_bit_in & ~env_prev_ff;
  assign cnt_load = cfg_wr & (avs_address_in == OFS_CNT_HI);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      env_prev_ff <= 1'b0;
    end else begin
      env_prev_ff <= aux_envelope_bit_in;
    end
  end

  // Low byte is staged, high byte write loads both
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_lo_hold_ff <= 8'h00;
    end else if (cfg_wr && avs_address_in == OFS_CNT_LO) begin
      cnt_lo_hold_ff <= wbyte;
    end
  end

  // Reading the low byte freezes the high byte for the next read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_hi_snap_ff <= 8'h00;
    end else if (rd_take && reachable && avs_address_in == OFS_CNT_LO) begin
      cnt_hi_snap_ff <= envelope_counter_ff[15:8];
    end
  end

  // Counts only in search mode; a load wins over a step
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      envelope_counter_ff <= 16'h0000;
    end else if (cnt_load) begin
      envelope_counter_ff <= {wbyte, cnt_lo_hold_ff};
    end else if (envelope_proc_enable_out && env_rise) begin
      if (eq_setup_ff.count_up_select) begin
        envelope_counter_ff <= envelope_counter_ff + 16'h0001;
      end else begin
        envelope_counter_ff <= envelope_counter_ff - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock recovery range control
  // ----------------------------------------------------------------------
  eqco_pll_t  pll_state_ff;
  logic [9:0] ret_cnt_ff;
  logic [9:0] ret_limit;
  logic       span_zero;

  assign loop_leak_enable_out = clk_setup_ff.loop_leak_enable;
  assign pll_span_select_out  = clk_setup_ff.pll_span_select;
  assign span_zero            = clk_setup_ff.pll_span_select == 2'b00;
  assign extended_range_out   = pll_state_ff == PLL_EXTENDED;
  assign ret_limit            = RET_BASE << clk_setup_ff.lock_return_delay;

  // Gain per range
  always_comb begin
    if (extended_range_out) begin
      loop_gain_out = GAIN_TWO + {1'b0, clk_setup_ff.extended_gain_field};
    end else if (clk_setup_ff.normal_gain_select) begin
      loop_gain_out = GAIN_ONE;
    end else begin
      loop_gain_out = GAIN_TWO;
    end
  end

  // Consecutive in-range bit periods
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ret_cnt_ff <= 10'h000;
    end else if (!extended_range_out || (bit_period_tick_in && !freq_in_normal_in)) begin
      ret_cnt_ff <= 10'h000;
    end else if (bit_period_tick_in) begin
      ret_cnt_ff <= ret_cnt_ff + 10'h001;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pll_state_ff <= PLL_NORMAL;
    end else if (span_zero) begin
      pll_state_ff <= PLL_NORMAL;
    end else if (bit_period_tick_in) begin
      case (pll_state_ff)
        PLL_NORMAL: begin
          if (!freq_in_normal_in) begin
            pll_state_ff <= PLL_EXTENDED;
          end
        end
        PLL_EXTENDED: begin
          if (freq_in_normal_in && ret_cnt_ff == ret_limit - 10'h001) begin
            pll_state_ff <= PLL_NORMAL;
          end
        end
        default: pll_state_ff <= PLL_NORMAL;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_eye_off;
    @(posedge clk_in) disable iff (!rstn_in)
      !eye_sel_ff.eye_dac_enable |=> eye_dac_code_out == EYE_IDLE;
  endproperty
  a_eye_off: assert property (p_eye_off) else $error("eye output not high when off");

  property p_eye_aux;
    @(posedge clk_in) disable iff (!rstn_in)
      eye_sel_ff.eye_dac_enable && eye_sel_ff.eye_channel_field == CHAN_AUX
      |=> eye_dac_code_out == $past(chan_in[8].eye);
  endproperty
  a_eye_aux: assert property (p_eye_aux) else $error("eye aux routing wrong");

  property p_pin_a_slice;
    @(posedge clk_in) disable iff (!rstn_in)
      pin_sel_ff[0].function_field == FN_SLICE && pin_sel_ff[0].channel_field == 4'h3
      |=> test_out_pin_a_out == {7'h00, $past(chan_in[3].sliced)};
  endproperty
  a_pin_a_slice: assert property (p_pin_a_slice) else $error("pin a slice wrong");

  property p_pin_b_rsv;
    @(posedge clk_in) disable iff (!rstn_in)
      (pin_sel_ff[1].function_field > FN_FREQ || pin_sel_ff[1].channel_field > CHAN_AUX &&
       pin_sel_ff[1].function_field != FN_FREQ) |=> test_out_pin_b_out == 8'h00;
  endproperty
  a_pin_b_rsv: assert property (p_pin_b_rsv) else $error("pin b reserved not zero");

  property p_cnt_step;
    @(posedge clk_in) disable iff (!rstn_in)
      envelope_proc_enable_out && env_rise && !cnt_load && eq_setup_ff.count_up_select
      |=> envelope_counter_ff == $past(envelope_counter_ff) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step up");

  property p_normal_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      eq_setup_ff.equalizer_mode_field == MODE_NORMAL && !cnt_load |=> $stable(envelope_counter_ff);
  endproperty
  a_normal_hold: assert property (p_normal_hold) else $error("counter moved in normal");

  property p_sleep_sync;
    @(posedge clk_in) disable iff (!rstn_in)
      sleeping |-> sync_ready_flag_out && !main_eq_enable_out && !aux_eq_enable_out;
  endproperty
  a_sleep_sync: assert property (p_sleep_sync) else $error("sleep outputs wrong");

  property p_off_block;
    @(posedge clk_in) disable iff (!rstn_in)
      sleeping && wr_take && avs_address_in == OFS_PIN_A |=> $stable(pin_sel_ff[0]);
  endproperty
  a_off_block: assert property (p_off_block) else $error("write taken while off");

  property p_span_zero;
    @(posedge clk_in) disable iff (!rstn_in)
      span_zero |=> !extended_range_out;
  endproperty
  a_span_zero: assert property (p_span_zero) else $error("extended with span zero");

  property p_gain_ext;
    @(posedge clk_in) disable iff (!rstn_in)
      extended_range_out |-> loop_gain_out == 3'(clk_setup_ff.extended_gain_field) + 3'h2;
  endproperty
  a_gain_ext: assert property (p_gain_ext) else $error("extended gain wrong");

  property p_wait_one;
    @(posedge clk_in) disable iff (!rstn_in)
      avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest longer than one cycle");

endmodule : eqco_top

`default_nettype wire
